// File: rtl/err_status_pkg.sv
// constants for the camera error status reporter
package err_status_pkg;
  // command frame fields
  localparam logic [7:0] STATUS_COMMAND_IDENTIFIER = 8'h43;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_REPLY = 1'b0;
  localparam logic [7:0] STATUS_DATA_LEN = 8'h02;
  // first status byte bit positions
  localparam int B1_NO_TRIGGER = 0;
  localparam int B1_RESET_SEEN = 1;
  localparam int B1_UNLOCKED = 2;
  localparam int B1_RSVD3 = 3;
  localparam int B1_UNKNOWN_ID = 4;
  localparam int B1_ACCESS_DENIED = 5;
  localparam int B1_LEN_MISMATCH = 6;
  localparam int B1_PARAM_RSVD = 7;
  // second status byte holds eight fault inputs in bit order
  localparam int B2_WIDTH = 8;
  // reset value of the flag word
  localparam logic [15:0] FLAGS_RESET = 16'h0002;
  // trigger watchdog: 5 s at 50 MHz
  localparam int CLK_HZ = 50_000_000;
  localparam int TRIG_TIMEOUT_S = 5;
  localparam longint TRIG_TIMEOUT_CYC = longint'(TRIG_TIMEOUT_S) * CLK_HZ;
  // reply sequencer states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_HDR = 2'b01,
    TX_DATA = 2'b10
  } tx_state_t;
endpackage

// File: rtl/camera_error_status_reporter.sv
// status flag collection and status command reply for the camera
`timescale 1ns/1ps
`default_nettype none

module camera_error_status_reporter
  import err_status_pkg::*;
#(
  parameter longint TRIG_TIMEOUT = TRIG_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // decoded command frame from the serial handler
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_command_identifier,
  input wire logic i_cmd_rw,
  input wire logic [7:0] i_cmd_len,
  // monitors
  input wire logic i_line_trigger_input,
  input wire logic i_unlocked,
  input wire logic i_unknown_id,
  input wire logic i_access_denied,
  input wire logic i_len_mismatch,
  input wire logic i_reset_flag_clr,
  input wire logic [B2_WIDTH-1:0] i_fault,
  // reply byte stream
  output logic o_tx_valid,
  output logic [7:0] o_tx_byte,
  output logic o_tx_last,
  input wire logic i_tx_ready,
  // flag word view
  output logic [15:0] o_error_flag_word
);

  logic [31:0] trig_cnt_reg;
  logic trig_prev_reg;
  logic no_trig_reg;
  logic reset_seen_reg;
  logic unknown_reg;
  logic denied_reg;
  logic lenbad_reg;
  logic [15:0] flag_word;
  tx_state_t tx_state_reg;
  logic [2:0] tx_idx_reg;
  logic status_read;
  logic [7:0] tx_next;

  // line trigger watchdog counts cycles since last rising edge
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      trig_cnt_reg <= 32'h0000_0000;
      trig_prev_reg <= 1'b0;
      no_trig_reg <= 1'b0;
    end else begin
      trig_prev_reg <= i_line_trigger_input;
      if (i_line_trigger_input && !trig_prev_reg) begin
        trig_cnt_reg <= 32'h0000_0000;
        no_trig_reg <= 1'b0;
      end else if (64'(trig_cnt_reg) >= 64'(TRIG_TIMEOUT - 1)) begin
        no_trig_reg <= 1'b1;
      end else begin
        trig_cnt_reg <= trig_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // reset flag set by reset itself, cleared only by explicit request
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      reset_seen_reg <= FLAGS_RESET[B1_RESET_SEEN];
    end else if (i_reset_flag_clr) begin
      reset_seen_reg <= 1'b0;
    end
  end

  // command protocol faults reflect the most recent command that is not a well formed status read
  // a status read keeps them, otherwise it could never report them
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      unknown_reg <= 1'b0;
      denied_reg <= 1'b0;
      lenbad_reg <= 1'b0;
    end else if (i_cmd_valid && !status_read) begin
      unknown_reg <= i_unknown_id;
      denied_reg <= i_access_denied;
      lenbad_reg <= i_len_mismatch;
    end
  end

  // assemble the flag word, one means present
  always_comb begin
    flag_word = 16'h0000;
    flag_word[B1_NO_TRIGGER] = no_trig_reg;
    flag_word[B1_RESET_SEEN] = reset_seen_reg;
    flag_word[B1_UNLOCKED] = i_unlocked;
    flag_word[B1_RSVD3] = 1'b0;
    flag_word[B1_UNKNOWN_ID] = unknown_reg;
    flag_word[B1_ACCESS_DENIED] = denied_reg;
    flag_word[B1_LEN_MISMATCH] = lenbad_reg;
    flag_word[B1_PARAM_RSVD] = 1'b0;
    flag_word[15:8] = i_fault;
  end

  // registered view of the flag word
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_error_flag_word <= 16'h0000;
    end else begin
      o_error_flag_word <= flag_word;
    end
  end

  // only a well formed status read is answered
  assign status_read = (i_command_identifier == STATUS_COMMAND_IDENTIFIER) &&
                       (i_cmd_rw == RW_READ) &&
                       (i_cmd_len == STATUS_DATA_LEN);

  // reply byte selection: id, flag, length, byte one, byte two
  always_comb begin
    case (tx_idx_reg)
      3'd0: tx_next = STATUS_COMMAND_IDENTIFIER;
      3'd1: tx_next = {7'h00, RW_REPLY};
      3'd2: tx_next = STATUS_DATA_LEN;
      3'd3: tx_next = o_error_flag_word[7:0];
      3'd4: tx_next = o_error_flag_word[15:8];
      default: tx_next = 8'h00;
    endcase
  end

  // reply sequencer, each flag byte sampled from the view as it is sent
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_state_reg <= TX_IDLE;
      tx_idx_reg <= 3'd0;
      o_tx_valid <= 1'b0;
      o_tx_byte <= 8'h00;
      o_tx_last <= 1'b0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (i_cmd_valid && status_read) begin
            tx_state_reg <= TX_HDR;
            tx_idx_reg <= 3'd0;
          end
        end
        TX_HDR: begin
          o_tx_valid <= 1'b1;
          o_tx_byte <= tx_next;
          o_tx_last <= (tx_idx_reg == 3'd4);
          tx_idx_reg <= tx_idx_reg + 3'd1;
          tx_state_reg <= TX_DATA;
        end
        TX_DATA: begin
          if (i_tx_ready) begin
            o_tx_valid <= 1'b0;
            o_tx_last <= 1'b0;
            if (o_tx_last) begin
              tx_state_reg <= TX_IDLE;
            end else begin
              tx_state_reg <= TX_HDR;
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // reserved bits stay low in the view
  a_rsvd_zero: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    !o_error_flag_word[B1_RSVD3] && !o_error_flag_word[B1_PARAM_RSVD])
    else $error("reserved status bit set");

  // well formed read starts a reply with the id byte
  a_read_reply: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (tx_state_reg == TX_IDLE && i_cmd_valid && status_read)
      |-> ##2 (o_tx_valid && o_tx_byte == STATUS_COMMAND_IDENTIFIER))
    else $error("status read not answered with id");

  // malformed status command does not start a reply
  a_bad_read: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (tx_state_reg == TX_IDLE && i_cmd_valid && !status_read)
      |=> tx_state_reg == TX_IDLE)
    else $error("malformed command answered");

  // last reply byte is the second flag byte
  a_last_byte: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (o_tx_valid && o_tx_last) |-> tx_idx_reg == 3'd5)
    else $error("reply length wrong");

  // trigger edge clears the no trigger flag next cycle
  a_trig_clear: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (i_line_trigger_input && !trig_prev_reg) |=> !no_trig_reg)
    else $error("trigger did not clear flag");

  // timeout sets the no trigger flag
  a_trig_set: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (64'(trig_cnt_reg) >= 64'(TRIG_TIMEOUT - 1) &&
     !(i_line_trigger_input && !trig_prev_reg)) |=> no_trig_reg)
    else $error("trigger timeout not flagged");

  // unlocked input appears in the view one cycle later, once out of reset
  a_unlock_view: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    $past(i_resetn) |-> o_error_flag_word[B1_UNLOCKED] == $past(i_unlocked))
    else $error("unlocked flag wrong");

  // second byte follows fault inputs, once out of reset
  a_fault_view: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    $past(i_resetn) |-> o_error_flag_word[15:8] == $past(i_fault))
    else $error("fault byte wrong");

  // protocol fault captured from a non status command
  a_proto_flag: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (i_cmd_valid && !status_read)
      |=> (unknown_reg == $past(i_unknown_id) &&
           denied_reg == $past(i_access_denied) &&
           lenbad_reg == $past(i_len_mismatch)))
    else $error("protocol flag not captured");

  // reset flag holds until cleared
  a_reset_hold: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (reset_seen_reg && !i_reset_flag_clr) |=> reset_seen_reg)
    else $error("reset flag lost");

  // a status read leaves the protocol fault flags as they were
  a_read_keeps: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (i_cmd_valid && status_read)
      |=> ($stable(unknown_reg) && $stable(denied_reg) &&
           $stable(lenbad_reg)))
    else $error("status read changed a protocol flag");

  // an unknown id verdict reaches the view two edges later
  a_unknown_seen: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (i_cmd_valid && !status_read && i_unknown_id) ##1 !i_cmd_valid
      |=> o_error_flag_word[B1_UNKNOWN_ID])
    else $error("unknown id not reported");

  // an access denied verdict reaches the view two edges later
  a_denied_seen: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (i_cmd_valid && !status_read && i_access_denied) ##1 !i_cmd_valid
      |=> o_error_flag_word[B1_ACCESS_DENIED])
    else $error("access denied not reported");

  // a length verdict reaches the view two edges later
  a_lenbad_seen: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (i_cmd_valid && !status_read && i_len_mismatch) ##1 !i_cmd_valid
      |=> o_error_flag_word[B1_LEN_MISMATCH])
    else $error("length mismatch not reported");

  // leaving reset always reports that a reset happened
  a_reset_set: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    $rose(i_resetn) |-> reset_seen_reg ##1 o_error_flag_word[B1_RESET_SEEN])
    else $error("reset not reported");

  // a reply byte stands until the host takes it
  a_byte_hold: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (o_tx_valid && !i_tx_ready)
      |=> (o_tx_valid && $stable(o_tx_byte) && $stable(o_tx_last)))
    else $error("reply byte changed before taken");

  // a taken byte is withdrawn on the next edge
  a_valid_drop: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (o_tx_valid && i_tx_ready) |=> !o_tx_valid)
    else $error("reply byte not withdrawn");

  // second and third reply bytes carry the reply flag and the length
  a_reply_hdr: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    o_tx_valid
      |-> ((tx_idx_reg != 3'd2 || o_tx_byte == {7'h00, RW_REPLY}) &&
           (tx_idx_reg != 3'd3 || o_tx_byte == STATUS_DATA_LEN)))
    else $error("reply header byte wrong");

endmodule

`default_nettype wire

// File: bench/host_model.sv
// host controller model: sends command frames, takes reply bytes
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input wire logic i_sys_clk,
  // command frame to the device
  output logic o_cmd_valid,
  output logic [7:0] o_command_identifier,
  output logic o_cmd_rw,
  output logic [7:0] o_cmd_len,
  // reply bytes from the device
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_byte,
  input wire logic i_tx_last,
  output logic o_tx_ready
);
  logic slow = 1'b0;
  logic [7:0] rx_q[$];
  int last_seen = 0;
  initial begin
    o_cmd_valid = 1'b0;
    o_command_identifier = 8'h00;
    o_cmd_rw = 1'b0;
    o_cmd_len = 8'h00;
    o_tx_ready = 1'b0;
  end
  // take bytes on handshake; stall every other cycle when slow
  always @(posedge i_sys_clk) begin
    if (i_tx_valid && o_tx_ready) begin
      rx_q.push_back(i_tx_byte);
      if (i_tx_last) last_seen++;
    end
    o_tx_ready <= #1 slow ? ~o_tx_ready : 1'b1;
  end
  // one frame held for a single cycle
  task automatic send(input logic [7:0] id, input logic rw,
                      input logic [7:0] len);
    @(posedge i_sys_clk);
    #1;
    o_cmd_valid = 1'b1;
    o_command_identifier = id;
    o_cmd_rw = rw;
    o_cmd_len = len;
    @(posedge i_sys_clk);
    #1;
    o_cmd_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: bench/test_camera_error_status_reporter.sv
// self-checking bench for the error status reporter
`timescale 1ns/1ps
`default_nettype none
module test_camera_error_status_reporter;
  import err_status_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic cmd_valid, cmd_rw, tx_ready, tx_valid, tx_last;
  logic [7:0] command_identifier, cmd_len, tx_byte;
  logic trig = 1'b0, trig_on = 1'b1;
  logic unlocked = 1'b0, clr = 1'b0;
  logic [2:0] verdict = 3'b000;
  logic [7:0] fault = 8'h00;
  logic [15:0] flags;
  logic [39:0] r;
  int n_errors = 0;
  int num_checks = 0;
  host_model host (.i_sys_clk(i_sys_clk), .o_cmd_valid(cmd_valid),
    .o_command_identifier(command_identifier), .o_cmd_rw(cmd_rw),
    .o_cmd_len(cmd_len), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte),
    .i_tx_last(tx_last), .o_tx_ready(tx_ready));
  camera_error_status_reporter #(.TRIG_TIMEOUT(100)) dut (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_cmd_valid(cmd_valid), .i_command_identifier(command_identifier),
    .i_cmd_rw(cmd_rw), .i_cmd_len(cmd_len),
    .i_line_trigger_input(trig), .i_unlocked(unlocked),
    .i_unknown_id(verdict[0]), .i_access_denied(verdict[1]),
    .i_len_mismatch(verdict[2]), .i_reset_flag_clr(clr),
    .i_fault(fault), .o_tx_valid(tx_valid), .o_tx_byte(tx_byte),
    .o_tx_last(tx_last), .i_tx_ready(tx_ready),
    .o_error_flag_word(flags));
  always #10 i_sys_clk = ~i_sys_clk;
  // line trigger toggles every 20 cycles while enabled
  always begin
    repeat (20) @(posedge i_sys_clk);
    if (trig_on) trig <= #1 ~trig;
  end
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // status read; five reply bytes packed in send order
  task automatic rd(output logic [39:0] v);
    int n;
    n = host.last_seen;
    host.rx_q.delete();
    host.send(STATUS_COMMAND_IDENTIFIER, RW_READ, STATUS_DATA_LEN);
    repeat (60) if (host.last_seen == n) @(posedge i_sys_clk);
    #1;
    v = {host.rx_q[0], host.rx_q[1], host.rx_q[2], host.rx_q[3],
         host.rx_q[4]};
    if (host.rx_q.size() != 5) v = 'x;
  endtask
  task automatic t_reset;
    check(flags, FLAGS_RESET);
    rd(r);
    check(r, 40'h43_0002_0200);
  endtask
  // live levels with a stalling host; reads leave flags unchanged
  task automatic t_levels;
    clr = 1'b1;
    fault = 8'hA5;
    unlocked = 1'b1;
    host.slow = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1 clr = 1'b0;
    rd(r);
    check(r, 40'h43_0002_04A5);
    rd(r);
    check(r, 40'h43_0002_04A5);
    fault = 8'h5A;
    unlocked = 1'b0;
    rd(r);
    check(r, 40'h43_0002_005A);
    fault = 8'h00;
    host.slow = 1'b0;
  endtask
  task automatic t_trigger;
    trig_on = 1'b0;
    repeat (130) @(posedge i_sys_clk);
    rd(r);
    check(r, 40'h43_0002_0100);
    trig_on = 1'b1;
    repeat (60) @(posedge i_sys_clk);
    rd(r);
    check(r, 40'h43_0002_0000);
  endtask
  // each verdict sets its own bit; malformed status reads are ignored
  task automatic t_proto;
    int n;
    for (int k = 0; k < 3; k++) begin
      verdict = 3'b001 << k;
      host.send(8'h50, 1'b0, 8'h01);
      verdict = 3'b000;
      rd(r);
      check(r[15:8], 8'h10 << k);
    end
    n = host.last_seen;
    host.send(STATUS_COMMAND_IDENTIFIER, RW_READ, 8'h03);
    host.send(STATUS_COMMAND_IDENTIFIER, RW_REPLY, STATUS_DATA_LEN);
    repeat (30) @(posedge i_sys_clk);
    check(host.last_seen - n, 0);
  endtask
  // mid-run reset reports the reset again after it was cleared
  task automatic t_rerst;
    #1 i_resetn = 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1 i_resetn = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    check(flags, FLAGS_RESET);
    rd(r);
    check(r, 40'h43_0002_0200);
  endtask
  initial begin
    repeat (12) @(posedge i_sys_clk);
    #1 i_resetn = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    t_reset();
    t_levels();
    t_trigger();
    t_proto();
    t_rerst();
    test_done();
  end
  // watchdog well beyond the expected run
  initial begin
    #200us;
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
